// File: design/abx_alu.v
// abx_alu.v: combinational arithmetic, shift and bit logic
// Assumes the caller picks which flags to keep per operation
`timescale 1ns/10ps
`include "abx_defs.vh"
module abx_alu (
   // Operation select
   input wire [2:0] op_in,
   input wire [2:0] bit_sel_in,
   // Operands
   input wire [7:0] acc_in,
   input wire [7:0] file_in,
   input wire carry_in,
   // Results
   output reg [7:0] result_out,
   output reg carry_out,
   output reg digit_carry_flag_out,
   output reg zero_out,
   output reg bit_val_out
);
   reg cin;
   reg [8:0] sum9;
   reg [4:0] nib5;
   reg [7:0] mask;

   // Result and flags for the selected operation
   always @* begin
      cin = (op_in == `ABX_OP_ADDC) ? carry_in : 1'b0; // [RULE3]
      sum9 = {1'b0, acc_in} + {1'b0, file_in} + {8'h00, cin}; // [RULE1] [RULE3]
      nib5 = {1'b0, acc_in[3:0]} + {1'b0, file_in[3:0]} + {4'h0, cin};
      mask = 8'h01 << bit_sel_in;
      result_out = file_in;
      carry_out = carry_in;
      digit_carry_flag_out = nib5[4];
      case (op_in)
         `ABX_OP_ADD, `ABX_OP_ADDC: begin
            result_out = sum9[7:0];
            carry_out = sum9[8];
         end
         `ABX_OP_ASR: begin
            result_out = {file_in[7], file_in[7:1]}; // [RULE5] [RULE6]
            carry_out = file_in[0]; // [RULE5]
         end
         `ABX_OP_BCLR: begin
            result_out = file_in & ~mask; // [RULE7]
         end
         default: begin
            result_out = file_in;
         end
      endcase
      zero_out = (result_out == 8'h00);
      bit_val_out = file_in[bit_sel_in]; // [RULE8] [RULE9]
   end
endmodule // abx_alu

// File: design/abx_defs.vh
// abx_defs.vh: offsets, fields, encodings and counts of the execution block
// Assumes inclusion by bare name from abx_top.v and abx_alu.v
// What this block does
// RULE1: Add accumulator and file, flags, select destination
// RULE2: Accumulator destination leaves file register untouched
// RULE3: Add with carry sums accumulator, file, carry
// RULE4: Add with carry stores per destination select
// RULE5: Shift right keeps bit7, bit0 into carry
// RULE6: One-place shift, carry and zero, destination select
// RULE7: Bit clear zeroes one bit, flags kept
// RULE8: Tested bit one: continue, one cycle
// RULE9: Tested bit zero: discard next, two cycles
// RULE10: Branch adds sign-extended offset to incremented counter
// RULE11: Branch offsets -256..255, always two cycles
// RULE12: Counter change or true test: NO_OPERATION cycle
// RULE13: Seven-bit file address joined with bank select
`ifndef ABX_DEFS_VH
`define ABX_DEFS_VH

// Register byte offsets
`define ABX_OFF_CTRL 8'h00
`define ABX_OFF_ACC 8'h04
`define ABX_OFF_STAT 8'h08
`define ABX_OFF_PC 8'h0c
`define ABX_OFF_BANK 8'h10
`define ABX_OFF_MADDR 8'h14
`define ABX_OFF_MDATA 8'h18
`define ABX_OFF_LAST 8'h1c
`define ABX_OFF_COUNT 8'h20

// Instruction word fields in the control register
`define ABX_OP_LSB 0
`define ABX_OP_MSB 2
`define ABX_DEST_BIT 3
`define ABX_BSEL_LSB 4
`define ABX_BSEL_MSB 6
`define ABX_FA_LSB 7
`define ABX_FA_MSB 13
`define ABX_LIT_LSB 14
`define ABX_LIT_MSB 22

// Operation codes
`define ABX_OP_ADD 3'h0
`define ABX_OP_ADDC 3'h1
`define ABX_OP_ASR 3'h2
`define ABX_OP_BCLR 3'h3
`define ABX_OP_SKIPC 3'h4
`define ABX_OP_BRA 3'h5
`define ABX_OP_NOP 3'h6

// Status bit positions
`define ABX_ST_C 0
`define ABX_ST_DC 1
`define ABX_ST_Z 2

// Last-instruction register bit positions
`define ABX_LAST_SKIP 2
`define ABX_LAST_BUSY 3

// Reset values
`define ABX_ACC_RST 8'h00
`define ABX_STAT_RST 3'h0
`define ABX_PC_RST 15'h0000

// Instruction cycle counts
`define ABX_CYC_ONE 2'h1
`define ABX_CYC_TWO 2'h2

// Bus responses
`define ABX_RESP_OKAY 2'h0
`define ABX_RESP_SLVERR 2'h2

`endif

// File: design/abx_top.v
// abx_top.v: instruction execution datapath with AXI4-Lite registers
// Assumes one AXI4-Lite master on clk_in; data memory held in flip-flops
`timescale 1ns/10ps
`include "abx_defs.vh"
module abx_top #(
   parameter BANK_W = 1,
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Write address channel
   input wire [ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   // Write data channel
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   // Write response channel
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // Read address channel
   input wire [ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   // Read data channel
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in
);
   localparam DEPTH = 128 << BANK_W;
   localparam S_IDLE = 2'h0, S_CYC1 = 2'h1, S_CYC2 = 2'h2; // Sequencer states

   // Bus capture state
   reg aw_held;
   reg w_held;
   reg [ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   // Architectural state
   reg [7:0] acc;
   reg [2:0] stat;
   reg [14:0] program_counter;
   reg [BANK_W-1:0] bank;
   reg [6:0] mem_addr;
   reg [7:0] mem [0:DEPTH-1];

   // Latched instruction and sequencing
   reg [1:0] state;
   reg [2:0] op;
   reg dest;
   reg [2:0] bit_sel;
   reg [6:0] faddr;
   reg [8:0] lit;
   reg incr_in_nop;
   reg [1:0] last_cycles;
   reg last_skip;
   reg [31:0] insn_count;

   // Combinational signals
   wire [7:0] alu_result;
   wire alu_carry;
   wire alu_dc;
   wire alu_zero;
   wire alu_bit;
   wire busy;
   wire wr_fire;
   wire [ADDR_W-1:0] wr_off;
   wire [ADDR_W-1:0] rd_off;
   wire [BANK_W+6:0] exec_addr;
   wire [BANK_W+6:0] sw_addr;
   wire [7:0] file_val;
   wire [14:0] branch_target;
   wire [31:0] ctrl_word;
   reg wr_ok;
   reg [31:0] rd_word;
   reg rd_ok;
   integer i;

   // Byte-lane merge of a write into an old word
   function [31:0] abx_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         abx_merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               abx_merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   assign busy = (state != S_IDLE);
   assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
   assign wr_off = {aw_addr[ADDR_W-1:2], 2'b00};
   assign rd_off = {s_axi_araddr_in[ADDR_W-1:2], 2'b00};
   assign ctrl_word = abx_merge(32'h0000_0000, w_data, w_strb);

   // Bank select on top, seven-bit offset below
   assign exec_addr = {bank, faddr}; // [RULE13]
   assign sw_addr = {bank, mem_addr}; // [RULE13]
   assign file_val = mem[exec_addr];

   // Next instruction address plus sign-extended nine-bit offset
   assign branch_target = program_counter + 15'h0001 + {{6{lit[8]}}, lit}; // [RULE10] [RULE11]

   abx_alu u_alu (
      .op_in(op),
      .bit_sel_in(bit_sel),
      .acc_in(acc),
      .file_in(file_val),
      .carry_in(stat[`ABX_ST_C]),
      .result_out(alu_result),
      .carry_out(alu_carry),
      .digit_carry_flag_out(alu_dc),
      .zero_out(alu_zero),
      .bit_val_out(alu_bit)
   );

   // Write legality; state changes are refused while an instruction runs
   always @* begin
      wr_ok = 1'b0;
      case (wr_off)
         `ABX_OFF_CTRL: begin
            wr_ok = !busy && (ctrl_word[`ABX_OP_MSB:`ABX_OP_LSB] <= `ABX_OP_NOP);
         end
         `ABX_OFF_ACC, `ABX_OFF_STAT, `ABX_OFF_PC, `ABX_OFF_BANK,
         `ABX_OFF_MADDR, `ABX_OFF_MDATA, `ABX_OFF_COUNT: begin
            wr_ok = !busy;
         end
         default: begin
            wr_ok = 1'b0;
         end
      endcase
   end

   // Read multiplexer; unused bits read as zero
   always @* begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (rd_off)
         `ABX_OFF_CTRL: rd_word = {9'h00, lit, faddr, bit_sel, dest, op};
         `ABX_OFF_ACC: rd_word = {24'h000000, acc};
         `ABX_OFF_STAT: rd_word = {29'h0000000, stat};
         `ABX_OFF_PC: rd_word = {17'h0000, program_counter};
         `ABX_OFF_BANK: rd_word[BANK_W-1:0] = bank;
         `ABX_OFF_MADDR: rd_word = {25'h000000, mem_addr};
         `ABX_OFF_MDATA: rd_word = {24'h000000, mem[sw_addr]};
         `ABX_OFF_LAST: rd_word = {28'h0000000, busy, last_skip, last_cycles};
         `ABX_OFF_COUNT: rd_word = insn_count;
         default: rd_ok = 1'b0;
      endcase
   end

   // Write address and data accepted in either order
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `ABX_RESP_OKAY;
      end else begin
         s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out);
         s_axi_wready_out <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out);
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Read channel: one read in flight, answer one cycle after the address
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `ABX_RESP_OKAY;
      end else begin
         s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= rd_ok ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // Sequencer: first cycle executes, optional second cycle is a no-op
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= S_IDLE;
         op <= `ABX_OP_NOP;
         dest <= 1'b0;
         bit_sel <= 3'h0;
         faddr <= 7'h00;
         lit <= 9'h000;
         incr_in_nop <= 1'b0;
         last_cycles <= 2'h0;
         last_skip <= 1'b0;
         insn_count <= 32'h0000_0000;
      end else begin
         case (state)
            S_IDLE: begin
               if (wr_fire && wr_ok && wr_off == `ABX_OFF_CTRL) begin
                  op <= ctrl_word[`ABX_OP_MSB:`ABX_OP_LSB];
                  dest <= ctrl_word[`ABX_DEST_BIT];
                  bit_sel <= ctrl_word[`ABX_BSEL_MSB:`ABX_BSEL_LSB];
                  faddr <= ctrl_word[`ABX_FA_MSB:`ABX_FA_LSB];
                  lit <= ctrl_word[`ABX_LIT_MSB:`ABX_LIT_LSB];
                  state <= S_CYC1;
               end else if (wr_fire && wr_ok && wr_off == `ABX_OFF_COUNT) begin
                  insn_count <= abx_merge(insn_count, w_data, w_strb);
               end
            end
            S_CYC1: begin
               insn_count <= insn_count + 32'h0000_0001;
               last_skip <= 1'b0;
               if (op == `ABX_OP_BRA) begin
                  // Branch always costs the extra cycle
                  state <= S_CYC2; // [RULE11] [RULE12]
                  incr_in_nop <= 1'b0;
                  last_cycles <= `ABX_CYC_TWO; // [RULE11]
               end else if (op == `ABX_OP_SKIPC && !alu_bit) begin
                  // Fetched follower is dropped; its slot runs as a no-op
                  state <= S_CYC2; // [RULE9] [RULE12]
                  incr_in_nop <= 1'b1;
                  last_cycles <= `ABX_CYC_TWO; // [RULE9]
                  last_skip <= 1'b1;
               end else begin
                  state <= S_IDLE; // [RULE8]
                  last_cycles <= `ABX_CYC_ONE; // [RULE8]
               end
            end
            S_CYC2: begin
               state <= S_IDLE;
               incr_in_nop <= 1'b0;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Accumulator, flags and program counter
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc <= `ABX_ACC_RST;
         stat <= `ABX_STAT_RST;
         program_counter <= `ABX_PC_RST;
         bank <= {BANK_W{1'b0}};
         mem_addr <= 7'h00;
      end else if (state == S_CYC1) begin
         if (op == `ABX_OP_BRA) begin
            program_counter <= branch_target; // [RULE10]
         end else begin
            program_counter <= program_counter + 15'h0001; // [RULE8]
         end
         case (op)
            `ABX_OP_ADD, `ABX_OP_ADDC: begin
               stat[`ABX_ST_C] <= alu_carry; // [RULE1] [RULE3]
               stat[`ABX_ST_DC] <= alu_dc; // [RULE1] [RULE3]
               stat[`ABX_ST_Z] <= alu_zero; // [RULE1] [RULE3]
               if (!dest) begin
                  acc <= alu_result; // [RULE1] [RULE2] [RULE4]
               end
            end
            `ABX_OP_ASR: begin
               stat[`ABX_ST_C] <= alu_carry; // [RULE5] [RULE6]
               stat[`ABX_ST_Z] <= alu_zero; // [RULE6]
               if (!dest) begin
                  acc <= alu_result; // [RULE6]
               end
            end
            default: begin
               // Bit clear, skip test, branch and no-op keep all flags
               stat <= stat; // [RULE7] [RULE8] [RULE10]
            end
         endcase
      end else if (state == S_CYC2) begin
         if (incr_in_nop) begin
            program_counter <= program_counter + 15'h0001; // [RULE9]
         end
      end else if (wr_fire && wr_ok) begin
         case (wr_off)
            `ABX_OFF_ACC: begin
               acc <= w_strb[0] ? w_data[7:0] : acc;
            end
            `ABX_OFF_STAT: begin
               if (w_strb[0]) begin
                  stat <= w_data[2:0];
               end
            end
            `ABX_OFF_PC: begin
               // Only the low fifteen bits exist; upper write data is dropped
               program_counter <= {w_strb[1] ? w_data[14:8] : program_counter[14:8],
                  w_strb[0] ? w_data[7:0] : program_counter[7:0]};
            end
            `ABX_OFF_BANK: begin
               if (w_strb[0]) begin
                  bank <= w_data[BANK_W-1:0];
               end
            end
            `ABX_OFF_MADDR: begin
               if (w_strb[0]) begin
                  mem_addr <= w_data[6:0];
               end
            end
            default: begin
               acc <= acc;
            end
         endcase
      end
   end

   // Data memory; only one writer per cycle since bus writes are refused while busy
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= 8'h00;
         end
      end else if (state == S_CYC1) begin
         if (op == `ABX_OP_BCLR) begin
            mem[exec_addr] <= alu_result; // [RULE7]
         end else if ((op == `ABX_OP_ADD || op == `ABX_OP_ADDC || op == `ABX_OP_ASR) && dest) begin
            mem[exec_addr] <= alu_result; // [RULE1] [RULE4] [RULE6]
         end
      end else if (wr_fire && wr_ok && wr_off == `ABX_OFF_MDATA && w_strb[0]) begin
         mem[sw_addr] <= w_data[7:0];
      end
   end
endmodule // abx_top

// File: sim/abx_assertions.sv
// abx_assertions.sv: bus timing checks for the execution block
// Assumes binding to abx_top; sees only its ports
`timescale 1ns/10ps
`include "abx_defs.vh"
module abx_assertions #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Write side
   input wire [ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   input wire s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   input wire s_axi_wready_out,
   input wire [1:0] s_axi_bresp_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // Read side
   input wire [ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire [1:0] s_axi_rresp_out,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Both halves of a write taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   // Write answer seen two edges after the handshake, read answer one; both stand until taken
   a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out) else $error("write answer late");
   a_wr_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write answer dropped");
   a_wr_drop: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out) else $error("bvalid stuck");
   a_wr_block: assert property ($rose(s_axi_bvalid_out) |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while answering");
   a_ready_back: assert property (s_axi_bvalid_out && s_axi_bready_in |=> ##[0:2] s_axi_awready_out)
      else $error("awready not back");
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer late");
   a_rd_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)
      && $stable(s_axi_rresp_out)) else $error("read answer changed");
   a_rd_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == `ABX_RESP_SLVERR |-> s_axi_rdata_out == 32'h0)
      else $error("refused read carries data");
   a_resp_code: assert property (s_axi_bvalid_out |-> s_axi_bresp_out inside {`ABX_RESP_OKAY, `ABX_RESP_SLVERR})
      else $error("bad write response");
endmodule // abx_assertions

bind abx_top abx_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
   .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
   .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
   .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);

// File: sim/abx_tb_top.sv
// abx_tb_top.sv: self-checking bench for the execution block
// Assumes abx_defs.vh on the include path; a bench AXI4-Lite master
`timescale 1ns/10ps
`include "abx_defs.vh"
module abx_tb_top;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [7:0] awaddr = 8'h00;
   reg [7:0] araddr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg [3:0] wstrb = 4'hf;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer n_fail = 0, n_compared = 0, seed = 67, i;
   reg [31:0] v, w, d;
   reg [1:0] r;
   reg [7:0] acc;
   reg [2:0] st;
   reg [14:0] pc;
   reg bk;
   // 200 MHz
   always #2.5 clk_in = ~clk_in;
   abx_top #(.BANK_W(1), .ADDR_W(8)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
   task close_out;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // Compare helpers, one per kind of result
   task chk_data(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task chk_resp(input [1:0] e, input [1:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH resp expected %h seen %h", e, g);
         end
      end
   endtask
   // Sentinel 3 never comes back from the slave, so a lost answer shows
   // Answer ready is raised late so that a waiting answer must stand
   task wr(input [7:0] a, input [31:0] dt, output [1:0] rs);
      integer k;
      begin
         @(posedge clk_in);
         awaddr <= a;
         wdata <= dt;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         rs = 2'h3;
         for (k = 0; k < 64 && rs === 2'h3; k = k + 1) begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (k == 2) bready <= 1'b1;
            if (bvalid && bready) begin
               rs = bresp;
               bready <= 1'b0;
            end
         end
      end
   endtask
   task rd(input [7:0] a, output [31:0] dt, output [1:0] rs);
      integer k;
      begin
         @(posedge clk_in);
         araddr <= a;
         arvalid <= 1'b1;
         rs = 2'h3;
         dt = 32'h0;
         for (k = 0; k < 64 && rs === 2'h3; k = k + 1) begin
            @(posedge clk_in);
            if (arready) arvalid <= 1'b0;
            if (k == 1) rready <= 1'b1;
            if (rvalid && rready) begin
               dt = rdata;
               rs = rresp;
               rready <= 1'b0;
            end
         end
      end
   endtask
   task wc(input [7:0] a, input [31:0] dt);
      begin
         wr(a, dt, r);
         chk_resp(`ABX_RESP_OKAY, r);
      end
   endtask
   task rc(input [7:0] a, input [31:0] e, input string nm);
      begin
         rd(a, d, r);
         chk_resp(`ABX_RESP_OKAY, r);
         chk_data(nm, e, d);
      end
   endtask
   // Load operands, work out the expected outcome, launch, read all back
   task run(input [2:0] op, input dd, input [2:0] b, input [6:0] fa, input [8:0] lit, input [7:0] fv,
      input [7:0] a0, input [2:0] s0, input [14:0] p0);
      reg [8:0] s;
      reg [4:0] h;
      reg [7:0] f, res;
      reg [1:0] cy;
      reg sk;
      reg [31:0] t;
      begin
         t = $random(seed);
         bk = t[0];
         wc(`ABX_OFF_BANK, {31'h0, bk});
         wc(`ABX_OFF_MADDR, {25'h0, fa});
         wc(`ABX_OFF_MDATA, {24'h0, fv});
         wc(`ABX_OFF_ACC, {24'h0, a0});
         wc(`ABX_OFF_STAT, {29'h0, s0});
         wc(`ABX_OFF_PC, {17'h0, p0});
         acc = a0;
         st = s0;
         f = fv;
         cy = 2'h1;
         sk = 1'b0;
         pc = p0 + 15'h1;
         s = a0 + fv + (op == `ABX_OP_ADDC ? s0[0] : 1'b0);
         h = a0[3:0] + fv[3:0] + (op == `ABX_OP_ADDC ? s0[0] : 1'b0);
         res = {fv[7], fv[7:1]};
         case (op)
            `ABX_OP_ADD, `ABX_OP_ADDC: begin
               st = {s[7:0] == 8'h00, h[4], s[8]};
               res = s[7:0];
            end
            `ABX_OP_ASR: st = {res == 8'h00, s0[1], fv[0]};
            `ABX_OP_BCLR: f[b] = 1'b0;
            `ABX_OP_SKIPC: if (!fv[b]) begin
               pc = p0 + 15'h2;
               cy = 2'h2;
               sk = 1'b1;
            end
            `ABX_OP_BRA: begin
               pc = p0 + 15'h1 + {{6{lit[8]}}, lit};
               cy = 2'h2;
            end
            default: ;
         endcase
         if (op <= `ABX_OP_ASR) begin
            if (dd) f = res;
            else acc = res;
         end
         wc(`ABX_OFF_CTRL, {9'h0, lit, fa, b, dd, op});
         rc(`ABX_OFF_ACC, {24'h0, acc}, "acc");
         rc(`ABX_OFF_STAT, {29'h0, st}, "status");
         rc(`ABX_OFF_PC, {17'h0, pc}, "pc");
         rc(`ABX_OFF_MDATA, {24'h0, f}, "file");
         rc(`ABX_OFF_LAST, {28'h0, 1'b0, sk, cy}, "last");
         $display("test op %0d done", op);
      end
   endtask
   // Main sequence: corners first, then random, then refusals
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      run(`ABX_OP_ADD, 1'b0, 3'h0, 7'h7f, 9'h0, 8'h80, 8'h80, 3'h0, 15'h0000);
      run(`ABX_OP_ADD, 1'b1, 3'h0, 7'h00, 9'h0, 8'h0f, 8'h01, 3'h7, 15'h0010);
      run(`ABX_OP_ADDC, 1'b0, 3'h0, 7'h21, 9'h0, 8'hff, 8'h00, 3'h1, 15'h0020);
      run(`ABX_OP_ADDC, 1'b1, 3'h0, 7'h22, 9'h0, 8'h7f, 8'h80, 3'h1, 15'h0030);
      run(`ABX_OP_ASR, 1'b0, 3'h0, 7'h30, 9'h0, 8'h81, 8'h55, 3'h2, 15'h0040);
      run(`ABX_OP_ASR, 1'b1, 3'h0, 7'h31, 9'h0, 8'h01, 8'h55, 3'h0, 15'h0050);
      run(`ABX_OP_BCLR, 1'b0, 3'h7, 7'h40, 9'h0, 8'hff, 8'h12, 3'h7, 15'h0060);
      run(`ABX_OP_BCLR, 1'b1, 3'h0, 7'h41, 9'h0, 8'hff, 8'h12, 3'h0, 15'h0070);
      run(`ABX_OP_SKIPC, 1'b0, 3'h7, 7'h50, 9'h0, 8'h80, 8'h00, 3'h5, 15'h0080);
      run(`ABX_OP_SKIPC, 1'b0, 3'h0, 7'h51, 9'h0, 8'hfe, 8'h00, 3'h2, 15'h7fff);
      run(`ABX_OP_BRA, 1'b0, 3'h0, 7'h60, 9'h100, 8'h00, 8'h00, 3'h7, 15'h0000);
      run(`ABX_OP_BRA, 1'b0, 3'h0, 7'h61, 9'h0ff, 8'h00, 8'h00, 3'h0, 15'h7f00);
      run(`ABX_OP_NOP, 1'b1, 3'h0, 7'h62, 9'h0, 8'h33, 8'h44, 3'h3, 15'h0100);
      for (i = 0; i < 60; i = i + 1) begin
         v = $random(seed);
         w = $random(seed);
         run(v[2:0] == 3'h7 ? `ABX_OP_NOP : v[2:0], v[3], v[6:4], v[13:7], v[22:14], w[7:0], w[15:8], w[18:16],
            w[31:17]);
      end
      // Refused accesses must leave state alone
      wr(`ABX_OFF_CTRL, 32'h7, r);
      chk_resp(`ABX_RESP_SLVERR, r);
      rc(`ABX_OFF_PC, {17'h0, pc}, "pc kept");
      wr(`ABX_OFF_LAST, 32'h0, r);
      chk_resp(`ABX_RESP_SLVERR, r);
      wr(8'h24, 32'h1, r);
      chk_resp(`ABX_RESP_SLVERR, r);
      rd(8'h24, d, r);
      chk_resp(`ABX_RESP_SLVERR, r);
      chk_data("unmapped", 32'h0, d);
      // Thirteen corners plus sixty random launches; refused ones never count
      rc(`ABX_OFF_COUNT, 32'h49, "count");
      $display("refusal tests done");
      close_out;
   end
   // Hang guard, far beyond the few thousand cycles the run needs
   initial begin
      repeat (40000) @(posedge clk_in);
      n_fail = n_fail + 1;
      $display("MISMATCH watchdog expected done seen timeout");
      close_out;
   end
endmodule // abx_tb_top
